// ### sbdl_defs.svh
`ifndef SBDL_DEFS_SVH
`define SBDL_DEFS_SVH

// -----------------------------------------------------------------
// Bit timing, in debug clock ticks
// -----------------------------------------------------------------
`define SBDL_BIT_TICKS 5'h10
`define SBDL_RX_SAMPLE 5'h0A
`define SBDL_TX_ONE_SPEEDUP 5'h07
`define SBDL_TX_ZERO_LOW 5'h0D
`define SBDL_TX_END 5'h0E
`define SBDL_TIMEOUT 10'h200
`define SBDL_SYNC_DETECT 8'h80
`define SBDL_SYNC_DELAY 8'h10
`define SBDL_SYNC_LOW 8'h80

// -----------------------------------------------------------------
// Command codes and transfer sizes
// -----------------------------------------------------------------
`define SBDL_CMD_BITS 5'h08
`define SBDL_CMD_BACKGROUND 8'h90
`define SBDL_CMD_READ_STATUS 8'hE4
`define SBDL_CMD_WRITE_CONTROL 8'hC4
`define SBDL_CMD_READ_BKPT 8'hE2
`define SBDL_CMD_WRITE_BKPT 8'hC2
`define SBDL_CMD_GO 8'h08
`define SBDL_CMD_TRACE1 8'h10
`define SBDL_CMD_TAGGO 8'h18

// -----------------------------------------------------------------
// Status/control byte fields and reset value
// -----------------------------------------------------------------
`define SBDL_SC_ENABLE 7
`define SBDL_SC_ACTIVE 6
`define SBDL_SC_BKPT_EN 5
`define SBDL_SC_CLK_SEL 3
`define SBDL_SC_RESET 8'h00

`endif

// ### sbdl_pkg.sv
package sbdl_pkg;

  // Command engine states, Gray ordered
  typedef enum logic [1:0] {
    SBDL_ST_CMD = 2'b00,
    SBDL_ST_RXD = 2'b01,
    SBDL_ST_TXD = 2'b11,
    SBDL_ST_SYN = 2'b10
  } sbdl_state_e;

  // Sync response phases
  typedef enum logic [1:0] {
    SBDL_SY_IDLE = 2'b00,
    SBDL_SY_WAIT = 2'b01,
    SBDL_SY_LOW = 2'b11,
    SBDL_SY_UP = 2'b10
  } sbdl_sync_e;

endpackage

// ### sbdl_pin_sync.sv
`timescale 1ns/1ps
module sbdl_pin_sync
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic pin_i,
  output logic level_o,
  output logic fall_o,
  output logic rise_o
);

  logic meta;
  logic sync;
  logic prev;

  // -----------------------------------------------------------------
  // Two-stage synchroniser plus edge history
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta <= 1'b1;
      sync <= 1'b1;
      prev <= 1'b1;
    end
    else
    begin
      meta <= pin_i;
      sync <= meta;
      prev <= sync;
    end
  end

  assign level_o = sync;
  assign fall_o = prev & ~sync;
  assign rise_o = ~prev & sync;

endmodule // sbdl_pin_sync

// ### sbdl_bit_link.sv
`timescale 1ns/1ps
`include "sbdl_defs.svh"

// Operation
// - Bits travel MSB first, nominally sixteen debug clock cycles each.
// - 512 cycles without host falling edge aborts the command, nothing else.
// - Clock select bit picks bus clock or alternate debug clock.
// - Host bit start seen two cycles after the edge; pin sampled ten cycles later.
// - Target leaves pin undriven during host-to-target bits.
// - Logic 1 answer: short high speedup pulse seven cycles after start.
// - Logic 0 answer: pin low thirteen cycles, then short high drive.
// - Speed request answered with a timed reference low pulse.
// - Pin level at reset selects background start or application start.
// - CPU, trace and resume commands need background mode; others anytime.
// - Background request also wakes CPU from stop and wait.
// - Watchdog held off while CPU sits in background mode.
// - Oscillator kept running in stop while debug is enabled.
// - One address breakpoint comparator, outside the CPU memory map.
// - Pod may attach to a running target without a reset.
// - Commands open with an 8-bit code; 8- or 16-bit data follows at once, with no delay slot.
// - Background command acts only when debug enable is set.
module sbdl_bit_link
  import sbdl_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic debug_pin_i,
  output logic debug_pin_o,
  output logic debug_pin_oe_n_o,
  input wire logic alternate_debug_clock_i,
  input wire logic cpu_active_bgnd_i,
  input wire logic [15:0] cpu_addr_i,
  output logic bgnd_req_o,
  output logic wake_o,
  output logic go_o,
  output logic trace_o,
  output logic cmd_valid_o,
  output logic [7:0] cmd_code_o,
  output logic reset_bgnd_o,
  output logic watchdog_hold_o,
  output logic osc_keep_o,
  output logic bkpt_hit_o
);

  logic pin_lvl;
  logic pin_fall;
  logic alt_rise;
  logic tick;
  logic [7:0] sc;
  logic [15:0] bkpt;
  sbdl_state_e state;
  sbdl_sync_e sy;
  logic in_bit;
  logic [4:0] bcnt;
  logic [4:0] nbits;
  logic [4:0] need;
  logic [15:0] shreg;
  logic [9:0] idle;
  logic [7:0] lowc;
  logic [7:0] sycnt;
  logic [1:0] strap;
  logic [7:0] code;
  logic [1:0] tgt;
  logic rx_done;
  logic tx_done;
  logic drive_low;
  logic speedup;
  logic txbit;
  logic start;
  logic abort;
  logic sync_hit;

  function automatic logic needs_bgnd(input logic [7:0] c);
    needs_bgnd = ~c[7];
  endfunction

  // -----------------------------------------------------------------
  // Pin and clock sampling
  // -----------------------------------------------------------------
  sbdl_pin_sync u_pin
  (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .pin_i(debug_pin_i),
    .level_o(pin_lvl),
    .fall_o(pin_fall),
    .rise_o()
  );

  sbdl_pin_sync u_alt
  (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .pin_i(alternate_debug_clock_i),
    .level_o(),
    .fall_o(),
    .rise_o(alt_rise)
  );

  assign tick = sc[`SBDL_SC_CLK_SEL] ? alt_rise : 1'b1;

  // -----------------------------------------------------------------
  // Bit timing
  // -----------------------------------------------------------------
  // Own drive glitch after a short host pulse must not restart the bit
  assign start = pin_fall & (sy == SBDL_SY_IDLE) & ~(in_bit & (state == SBDL_ST_TXD));
  assign txbit = shreg[15];
  assign rx_done = in_bit & (state != SBDL_ST_TXD) & (bcnt == `SBDL_RX_SAMPLE);
  assign tx_done = in_bit & (state == SBDL_ST_TXD) & (bcnt == `SBDL_TX_END);
  assign drive_low = (in_bit & (state == SBDL_ST_TXD) & ~txbit & (bcnt < `SBDL_TX_ZERO_LOW))
    | (sy == SBDL_SY_LOW);
  assign speedup = (in_bit & (state == SBDL_ST_TXD) & txbit & (bcnt == `SBDL_TX_ONE_SPEEDUP))
    | (in_bit & (state == SBDL_ST_TXD) & ~txbit & (bcnt == `SBDL_TX_ZERO_LOW))
    | (sy == SBDL_SY_UP);
  assign debug_pin_o = speedup;
  assign debug_pin_oe_n_o = ~(drive_low | speedup);
  assign sync_hit = ~pin_lvl & (lowc == `SBDL_SYNC_DETECT);
  assign abort = (idle == `SBDL_TIMEOUT) & ((state != SBDL_ST_CMD) | (nbits != 5'h00));
  assign code = {shreg[6:0], pin_lvl};

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      in_bit <= 1'b0;
      bcnt <= 5'h00;
    end
    else if (start)
    begin
      in_bit <= 1'b1;
      bcnt <= 5'h00;
    end
    else if (rx_done | tx_done | sync_hit | abort)
    begin
      in_bit <= 1'b0;
    end
    else if (in_bit & tick & (bcnt != `SBDL_BIT_TICKS))
    begin
      bcnt <= bcnt + 5'h01;
    end
  end

  // Ticks since last host edge
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      idle <= 10'h000;
    end
    else if (start)
    begin
      idle <= 10'h000;
    end
    else if (tick & (idle != `SBDL_TIMEOUT))
    begin
      idle <= idle + 10'h001;
    end
  end

  // -----------------------------------------------------------------
  // Speed measurement request
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      lowc <= 8'h00;
    end
    else if (pin_lvl | (sy != SBDL_SY_IDLE))
    begin
      lowc <= 8'h00;
    end
    else if (tick & (lowc != `SBDL_SYNC_DETECT))
    begin
      lowc <= lowc + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sy <= SBDL_SY_IDLE;
      sycnt <= 8'h00;
    end
    else
    begin
      case (sy)
        SBDL_SY_IDLE:
        begin
          sycnt <= 8'h00;
          if ((state == SBDL_ST_SYN) & pin_lvl)
          begin
            sy <= SBDL_SY_WAIT;
          end
        end
        SBDL_SY_WAIT:
        begin
          if (tick)
          begin
            sycnt <= sycnt + 8'h01;
            if (sycnt == `SBDL_SYNC_DELAY - 8'h01)
            begin
              sy <= SBDL_SY_LOW;
              sycnt <= 8'h00;
            end
          end
        end
        SBDL_SY_LOW:
        begin
          if (tick)
          begin
            sycnt <= sycnt + 8'h01;
            if (sycnt == `SBDL_SYNC_LOW - 8'h01)
            begin
              sy <= SBDL_SY_UP;
            end
          end
        end
        SBDL_SY_UP:
        begin
          if (tick)
          begin
            sy <= SBDL_SY_IDLE;
          end
        end
        default:
        begin
          sy <= SBDL_SY_IDLE;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Command engine
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state <= SBDL_ST_CMD;
      nbits <= 5'h00;
      need <= `SBDL_CMD_BITS;
      shreg <= 16'h0000;
      tgt <= 2'b00;
    end
    else if (sync_hit)
    begin
      state <= SBDL_ST_SYN;
      nbits <= 5'h00;
    end
    else if (abort)
    begin
      state <= SBDL_ST_CMD;
      nbits <= 5'h00;
      need <= `SBDL_CMD_BITS;
    end
    else
    begin
      case (state)
        SBDL_ST_CMD:
        begin
          if (rx_done)
          begin
            shreg <= {shreg[14:0], pin_lvl};
            nbits <= nbits + 5'h01;
            if (nbits + 5'h01 == `SBDL_CMD_BITS)
            begin
              nbits <= 5'h00;
              case (code)
                `SBDL_CMD_READ_STATUS:
                begin
                  state <= SBDL_ST_TXD;
                  need <= 5'h08;
                  shreg <= {sc[7:7], cpu_active_bgnd_i, sc[5:0], 8'h00};
                end
                `SBDL_CMD_READ_BKPT:
                begin
                  state <= SBDL_ST_TXD;
                  need <= 5'h10;
                  shreg <= bkpt;
                end
                `SBDL_CMD_WRITE_CONTROL:
                begin
                  state <= SBDL_ST_RXD;
                  need <= 5'h08;
                  tgt <= 2'b01;
                end
                `SBDL_CMD_WRITE_BKPT:
                begin
                  state <= SBDL_ST_RXD;
                  need <= 5'h10;
                  tgt <= 2'b10;
                end
                default:
                begin
                  state <= SBDL_ST_CMD;
                end
              endcase
            end
          end
        end
        SBDL_ST_RXD:
        begin
          if (rx_done)
          begin
            shreg <= {shreg[14:0], pin_lvl};
            nbits <= nbits + 5'h01;
            if (nbits + 5'h01 == need)
            begin
              state <= SBDL_ST_CMD;
              nbits <= 5'h00;
              need <= `SBDL_CMD_BITS;
            end
          end
        end
        SBDL_ST_TXD:
        begin
          if (tx_done)
          begin
            shreg <= {shreg[14:0], 1'b0};
            nbits <= nbits + 5'h01;
            if (nbits + 5'h01 == need)
            begin
              state <= SBDL_ST_CMD;
              nbits <= 5'h00;
              need <= `SBDL_CMD_BITS;
            end
          end
        end
        SBDL_ST_SYN:
        begin
          if (sy == SBDL_SY_UP)
          begin
            state <= SBDL_ST_CMD;
            need <= `SBDL_CMD_BITS;
          end
        end
        default:
        begin
          state <= SBDL_ST_CMD;
        end
      endcase
    end
  end

  // Control and breakpoint writes
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sc <= `SBDL_SC_RESET;
      bkpt <= 16'h0000;
    end
    else if ((state == SBDL_ST_RXD) & rx_done & (nbits + 5'h01 == need) & ~abort & ~sync_hit)
    begin
      if (tgt == 2'b01)
      begin
        sc <= {shreg[6:0], pin_lvl};
      end
      else
      begin
        bkpt <= {shreg[14:0], pin_lvl};
      end
    end
    else if (strap == 2'b10 & ~pin_lvl)
    begin
      sc[`SBDL_SC_ENABLE] <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // CPU side strobes
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      bgnd_req_o <= 1'b0;
      wake_o <= 1'b0;
      go_o <= 1'b0;
      trace_o <= 1'b0;
      cmd_valid_o <= 1'b0;
      cmd_code_o <= 8'h00;
    end
    else
    begin
      bgnd_req_o <= 1'b0;
      wake_o <= 1'b0;
      go_o <= 1'b0;
      trace_o <= 1'b0;
      cmd_valid_o <= 1'b0;
      if ((state == SBDL_ST_CMD) & rx_done & (nbits + 5'h01 == `SBDL_CMD_BITS)
        & ~abort & ~sync_hit & (cpu_active_bgnd_i | ~needs_bgnd(code)))
      begin
        cmd_valid_o <= 1'b1;
        cmd_code_o <= code;
        if ((code == `SBDL_CMD_BACKGROUND) & sc[`SBDL_SC_ENABLE])
        begin
          bgnd_req_o <= 1'b1;
          wake_o <= 1'b1;
        end
        go_o <= (code == `SBDL_CMD_GO) | (code == `SBDL_CMD_TAGGO);
        trace_o <= code == `SBDL_CMD_TRACE1;
      end
    end
  end

  // Reset-time mode pick, taken once the pin synchroniser has settled
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      strap <= 2'b00;
      reset_bgnd_o <= 1'b0;
    end
    else if (strap != 2'b11)
    begin
      strap <= strap + 2'b01;
      if (strap == 2'b10)
      begin
        reset_bgnd_o <= ~pin_lvl;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      watchdog_hold_o <= 1'b0;
      osc_keep_o <= 1'b0;
      bkpt_hit_o <= 1'b0;
    end
    else
    begin
      watchdog_hold_o <= cpu_active_bgnd_i;
      osc_keep_o <= sc[`SBDL_SC_ENABLE];
      bkpt_hit_o <= sc[`SBDL_SC_BKPT_EN] & (cpu_addr_i == bkpt);
    end
  end

endmodule // sbdl_bit_link

// ### sbdl_bit_link_checker.sv
`timescale 1ns/1ps
module sbdl_bit_link_checker
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic cpu_active_bgnd_i,
  input wire logic debug_pin_o,
  input wire logic debug_pin_oe_n_o,
  input wire logic bgnd_req_o,
  input wire logic wake_o,
  input wire logic go_o,
  input wire logic trace_o,
  input wire logic cmd_valid_o,
  input wire logic reset_bgnd_o,
  input wire logic watchdog_hold_o,
  input wire logic osc_keep_o,
  input wire logic bkpt_hit_o
);
  // ---------------------------------
  // Helper counters
  // ---------------------------------
  logic [2:0] up;
  logic [7:0] lowc;
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      up <= 3'h0;
    else if (up != 3'h7)
      up <= up + 3'h1;
  end
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      lowc <= 8'h00;
    else if (!debug_pin_oe_n_o && !debug_pin_o)
      lowc <= lowc + 8'h01;
    else
      lowc <= 8'h00;
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);
  property p_wdog;
    up > 3'h1 |-> watchdog_hold_o == $past(cpu_active_bgnd_i);
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog hold wrong");
  property p_wake;
    bgnd_req_o |-> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_bgnd_en;
    bgnd_req_o |-> osc_keep_o;
  endproperty
  a_bgnd_en: assert property (p_bgnd_en) else $error("bgnd while off");
  property p_go_bg;
    (go_o || trace_o) |-> watchdog_hold_o;
  endproperty
  a_go_bg: assert property (p_go_bg) else $error("go outside bgnd");
  property p_speed;
    (!debug_pin_oe_n_o && debug_pin_o) |=> debug_pin_oe_n_o;
  endproperty
  a_speed: assert property (p_speed) else $error("long speedup");
  property p_zero;
    (!debug_pin_oe_n_o && debug_pin_o && lowc != 8'h00) |-> (lowc == 8'h0D || lowc == 8'h80);
  endproperty
  a_zero: assert property (p_zero) else $error("low length");
  property p_pulse;
    cmd_valid_o |=> !cmd_valid_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("strobe long");
  property p_strap;
    up == 3'h7 |-> $stable(reset_bgnd_o);
  endproperty
  a_strap: assert property (p_strap) else $error("strap moved");
  c_bgnd: cover property (bgnd_req_o);
  c_go: cover property (go_o);
  c_sync: cover property (lowc == 8'h80);
  c_bkpt: cover property (bkpt_hit_o);
endmodule // sbdl_bit_link_checker

// ### sbdl_pod.sv
`timescale 1ns/1ps
module sbdl_pod
(
  input wire logic clk_i,
  input wire logic pin_i,
  input wire logic oe_n_i,
  output logic wire_o
);
  // ---------------------------------
  // Host side of the wire
  // ---------------------------------
  logic low;
  int k;
  initial low = 1'b0;
  initial k = 1;
  // Pullup wins when nobody drives
  assign wire_o = low ? 1'b0 : (!oe_n_i ? pin_i : 1'b1);
  task automatic bit_out(input logic b);
    @(negedge clk_i);
    low = 1'b1;
    repeat ((b ? 4 : 16) * k) @(negedge clk_i);
    low = 1'b0;
    repeat ((b ? 16 : 4) * k) @(negedge clk_i);
  endtask
  task automatic bit_in(output logic b);
    @(negedge clk_i);
    low = 1'b1;
    repeat (2 * k) @(negedge clk_i);
    low = 1'b0;
    repeat (8 * k) @(negedge clk_i);
    b = wire_o;
    repeat (12 * k) @(negedge clk_i);
  endtask
  task automatic send8(input logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      bit_out(v[i]);
  endtask
  task automatic recv8(output logic [7:0] v);
    for (int i = 7; i >= 0; i--)
      bit_in(v[i]);
  endtask
  task automatic hold(input int n);
    low = 1'b1;
    repeat (n) @(negedge clk_i);
    low = 1'b0;
  endtask
  task automatic gap();
    repeat (16 * k) @(negedge clk_i);
  endtask
endmodule // sbdl_pod

// ### sbdl_bit_link_bench.sv
`timescale 1ns/1ps
module sbdl_bit_link_bench;
  logic clk_i;
  logic arst_n_i;
  logic wire_l;
  logic pin_o;
  logic oe_n;
  logic cpu_bg;
  logic [15:0] addr;
  logic bgnd_req, wake, go, trace, cmd_valid, reset_bgnd, wdog, osc, bkpt;
  logic [7:0] code;
  logic [7:0] rd;
  logic [15:0] bk;
  logic [7:0] q[$];
  int fail_count;
  int compares;
  int bg_n;
  int go_n;
  int tr_n;
  int wk_n;
  logic alt;
  int seed;
  int n;
  initial clk_i = 1'b0;
  always #20 clk_i = ~clk_i;
  initial alt = 1'b0;
  always #80 alt = ~alt;
  sbdl_bit_link sbdl_bit_link_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .debug_pin_i(wire_l),
    .debug_pin_o(pin_o), .debug_pin_oe_n_o(oe_n), .alternate_debug_clock_i(alt),
    .cpu_active_bgnd_i(cpu_bg), .cpu_addr_i(addr), .bgnd_req_o(bgnd_req), .wake_o(wake),
    .go_o(go), .trace_o(trace), .cmd_valid_o(cmd_valid), .cmd_code_o(code),
    .reset_bgnd_o(reset_bgnd), .watchdog_hold_o(wdog), .osc_keep_o(osc), .bkpt_hit_o(bkpt));
  sbdl_pod sbdl_pod_i (.clk_i(clk_i), .pin_i(pin_o), .oe_n_i(oe_n), .wire_o(wire_l));
  // ---------------------------------
  // Checking tasks
  // ---------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input bit ok);
    if (ok)
      q.push_back(c);
    sbdl_pod_i.send8(c);
  endtask
  task automatic status(input logic [7:0] e);
    cmd(8'hE4, 1'b1);
    sbdl_pod_i.recv8(rd);
    chk("status", {8'h00, e}, {8'h00, rd});
  endtask
  task automatic do_reset(input logic lvl);
    @(negedge clk_i);
    arst_n_i = 1'b0;
    sbdl_pod_i.low = !lvl;
    repeat (12) @(negedge clk_i);
    arst_n_i = 1'b1;
    repeat (8) @(negedge clk_i);
    sbdl_pod_i.low = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(negedge clk_i)
  begin
    if (arst_n_i === 1'b1 && cmd_valid === 1'b1)
    begin
      if (q.size() == 0)
        chk("cmd_valid", 16'h0000, 16'h0001);
      else
        chk("cmd_code", {8'h00, q.pop_front()}, {8'h00, code});
    end
    if (bgnd_req === 1'b1)
      bg_n++;
    if (go === 1'b1)
      go_n++;
    if (trace === 1'b1)
      tr_n++;
    if (wake === 1'b1)
      wk_n++;
  end
  // ---------------------------------
  // Main sequence
  // ---------------------------------
  initial
  begin
    seed = 32'h649F;
    arst_n_i = 1'b0;
    cpu_bg = 1'b0;
    addr = 16'h0000;
    fail_count = 0;
    compares = 0;
    bg_n = 0;
    go_n = 0;
    tr_n = 0;
    wk_n = 0;
    do_reset(1'b1);
    chk("reset_bgnd", 16'h0000, {15'h0000, reset_bgnd});
    chk("oe_n", 16'h0001, {15'h0000, oe_n});
    cmd(8'h90, 1'b1);
    sbdl_pod_i.gap();
    chk("bgnd_off", 16'h0000, bg_n[15:0]);
    $display("test reset done");
    cmd(8'hC4, 1'b1);
    sbdl_pod_i.send8(8'hA0);
    repeat (4) @(negedge clk_i);
    chk("osc_keep", 16'h0001, {15'h0000, osc});
    status(8'hA0);
    cmd(8'h90, 1'b1);
    sbdl_pod_i.gap();
    chk("bgnd_on", 16'h0001, bg_n[15:0]);
    chk("wake", 16'h0001, wk_n[15:0]);
    $display("test control done");
    cmd(8'hC4, 1'b1);
    sbdl_pod_i.send8(8'hA8);
    sbdl_pod_i.k = 4;
    cmd(8'h90, 1'b1);
    sbdl_pod_i.gap();
    chk("bgnd_alt", 16'h0002, bg_n[15:0]);
    cmd(8'hC4, 1'b1);
    sbdl_pod_i.send8(8'hA0);
    sbdl_pod_i.k = 1;
    $display("test clock select done");
    cmd(8'h08, 1'b0);
    sbdl_pod_i.gap();
    chk("go_run", 16'h0000, go_n[15:0]);
    cpu_bg = 1'b1;
    cmd(8'h08, 1'b1);
    sbdl_pod_i.gap();
    cmd(8'h10, 1'b1);
    sbdl_pod_i.gap();
    chk("go_bg", 16'h0001, go_n[15:0]);
    chk("trace", 16'h0001, tr_n[15:0]);
    chk("wdog", 16'h0001, {15'h0000, wdog});
    status(8'hE0);
    cpu_bg = 1'b0;
    $display("test modes done");
    bk = $random(seed);
    cmd(8'hC2, 1'b1);
    sbdl_pod_i.send8(bk[15:8]);
    sbdl_pod_i.send8(bk[7:0]);
    cmd(8'hE2, 1'b1);
    sbdl_pod_i.recv8(rd);
    chk("bkpt_hi", {8'h00, bk[15:8]}, {8'h00, rd});
    sbdl_pod_i.recv8(rd);
    chk("bkpt_lo", {8'h00, bk[7:0]}, {8'h00, rd});
    addr = bk;
    repeat (3) @(negedge clk_i);
    chk("bkpt_hit", 16'h0001, {15'h0000, bkpt});
    addr = bk ^ 16'h0001;
    repeat (3) @(negedge clk_i);
    chk("bkpt_miss", 16'h0000, {15'h0000, bkpt});
    $display("test breakpoint done");
    for (int i = 7; i > 3; i--)
      sbdl_pod_i.bit_out(1'b1);
    repeat (600) @(negedge clk_i);
    status(8'hA0);
    $display("test timeout done");
    sbdl_pod_i.hold(140);
    n = 0;
    for (int i = 0; i < 400; i++)
    begin
      @(negedge clk_i);
      if (oe_n === 1'b0 && pin_o === 1'b0)
        n++;
    end
    chk("sync_low", 16'h0080, n[15:0]);
    $display("test sync done");
    do_reset(1'b0);
    chk("reset_bgnd", 16'h0001, {15'h0000, reset_bgnd});
    chk("osc_strap", 16'h0001, {15'h0000, osc});
    $display("test strap done");
    n = q.size();
    chk("queue", 16'h0000, n[15:0]);
    end_of_test();
  end
endmodule // sbdl_bit_link_bench
bind sbdl_bit_link sbdl_bit_link_checker sbdl_bit_link_checker_i (.clk_i(clk_i),
  .arst_n_i(arst_n_i), .cpu_active_bgnd_i(cpu_active_bgnd_i), .debug_pin_o(debug_pin_o),
  .debug_pin_oe_n_o(debug_pin_oe_n_o), .bgnd_req_o(bgnd_req_o), .wake_o(wake_o),
  .go_o(go_o), .trace_o(trace_o), .cmd_valid_o(cmd_valid_o), .reset_bgnd_o(reset_bgnd_o),
  .watchdog_hold_o(watchdog_hold_o), .osc_keep_o(osc_keep_o), .bkpt_hit_o(bkpt_hit_o));
